// ===== alu_defs.svh
// shared constants for the rotate, subtract and skip datapath
// How it works
// - copy rotate left into working register, flags kept
// - rotate left through carry, memory written back
// - rotate left through carry, result to register
// - rotate right in place, flags kept
// - copy rotate right into register, flags kept
// - rotate right through carry, memory written back
// - rotate right through carry, result to register
// - register minus memory minus inverted carry
// - register minus immediate minus inverted carry
// - borrow subtract written back to memory
// - subtracts update six arithmetic flags
// - carry set unless the subtract borrows; plain: no borrow in
// - plain difference written back to memory
// - decrement memory, skip when zero
// - decrement into register, skip when zero
// - increment memory, skip when zero, flags kept
// - increment into register, skip when zero
// - skip instructions take two cycles, dummy slot
// - skip when memory or bit nonzero
// - byte set writes all ones
// - bit set forces one selected bit
// - swap memory nibbles in place
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH
`define DATA_W 8
`define MSB_BIT 7
`define HALF_BIT 3
`define NIB_W 4
`define BIT_SEL_W 3
`define OP_W 5
`define ONE_VAL 8'h01
`define ALL_ONES 8'hff
`define ZERO_VAL 8'h00
`define WREG_RST 8'h00
`define FLAG_RST 1'b0
`endif

// ===== alu_pkg.sv
// types shared by the datapath core, its units and their bundle
`include "alu_defs.svh"
package alu_pkg;
	typedef enum logic [`OP_W-1:0] {
		nop = 5'b00000,
		rotate_left_copy = 5'b00001,
		rotate_left_thru_carry = 5'b00010,
		rotate_left_thru_carry_copy = 5'b00011,
		rotate_right = 5'b00100,
		rotate_right_copy = 5'b00101,
		rotate_right_thru_carry = 5'b00110,
		rotate_right_thru_carry_copy = 5'b00111,
		subtract_plain = 5'b01000,
		subtract_immediate = 5'b01001,
		difference_to_memory = 5'b01010,
		subtract_with_borrow = 5'b01011,
		subtract_borrow_immediate = 5'b01100,
		subtract_borrow_to_memory = 5'b01101,
		decrement_skip_on_zero = 5'b01110,
		decrement_skip_on_zero_copy = 5'b01111,
		increment_skip_on_zero = 5'b10000,
		increment_skip_on_zero_copy = 5'b10001,
		skip_if_nonzero = 5'b10010,
		skip_if_nonzero_bit = 5'b10011,
		byte_set = 5'b10100,
		bit_set = 5'b10101,
		nibble_swap = 5'b10110
	} op_t;
	typedef enum logic [0:0] {
		run = 1'b0,
		dummy = 1'b1
	} phase_t;
	typedef struct packed {
		logic c;
		logic z;
		logic half_carry;
		logic signed_wrap;
		logic signed_carry;
		logic chained_zero;
	} flags_t;
	typedef struct packed {
		phase_t phase;
		logic [`DATA_W-1:0] wreg;
		logic mem_we;
		logic [`DATA_W-1:0] mem_data;
		flags_t fl;
		logic skip;
	} core_state_t;
endpackage : alu_pkg

// ===== alu_if.sv
// operand and result bundle between the datapath core and its two units
`include "alu_defs.svh"
interface alu_if;
	import alu_pkg::*;
	logic [`DATA_W-1:0] opa;
	logic [`DATA_W-1:0] opb;
	logic carry_in;
	logic use_borrow;
	op_t op;
	logic [`BIT_SEL_W-1:0] bit_sel;
	logic [`DATA_W-1:0] diff;
	logic sub_c;
	logic sub_half_carry;
	logic sub_signed_wrap;
	logic sub_signed_carry;
	logic [`DATA_W-1:0] sh_res;
	logic sh_c;
	modport core (output opa, opb, carry_in, use_borrow, op, bit_sel,
		input diff, sub_c, sub_half_carry, sub_signed_wrap, sub_signed_carry, sh_res, sh_c);
	modport subtract (input opa, opb, carry_in, use_borrow,
		output diff, sub_c, sub_half_carry, sub_signed_wrap, sub_signed_carry);
	modport shifter (input opb, carry_in, op, bit_sel, output sh_res, sh_c);
endinterface : alu_if

// ===== sub_unit.sv
// eight-bit subtractor with borrow and its flag terms
`include "alu_defs.svh"
module sub_unit (
	alu_if.subtract bus
);
	import alu_pkg::*;
	logic cin;
	logic [`DATA_W:0] sum;
	logic [`HALF_BIT+1:0] low_sum;
	always_comb
	begin
		// carry high means no borrow, so a plain subtract feeds a one
		cin = bus.use_borrow ? bus.carry_in : 1'b1;
		sum = {1'b0, bus.opa} + {1'b0, ~bus.opb} + {{`DATA_W{1'b0}}, cin};
		low_sum = {1'b0, bus.opa[`HALF_BIT:0]} + {1'b0, ~bus.opb[`HALF_BIT:0]}
			+ {{(`HALF_BIT+1){1'b0}}, cin};
		bus.diff = sum[`DATA_W-1:0];
		bus.sub_c = sum[`DATA_W];
		bus.sub_half_carry = low_sum[`HALF_BIT+1];
		bus.sub_signed_wrap = (bus.opa[`MSB_BIT] != bus.opb[`MSB_BIT])
			&& (sum[`MSB_BIT] != bus.opa[`MSB_BIT]);
		bus.sub_signed_carry = bus.sub_signed_wrap ^ sum[`MSB_BIT];
	end
endmodule : sub_unit

// ===== shift_unit.sv
// rotate, step, set and swap results for a memory operand
`include "alu_defs.svh"
module shift_unit (
	alu_if.shifter bus
);
	import alu_pkg::*;
	logic [`DATA_W-1:0] b;
	always_comb
	begin
		b = bus.opb;
		bus.sh_res = b;
		bus.sh_c = bus.carry_in;
		unique case (bus.op)
			rotate_left_copy:
				bus.sh_res = {b[`DATA_W-2:0], b[`MSB_BIT]};
			rotate_left_thru_carry, rotate_left_thru_carry_copy:
			begin
				bus.sh_res = {b[`DATA_W-2:0], bus.carry_in};
				bus.sh_c = b[`MSB_BIT];
			end
			rotate_right, rotate_right_copy:
				bus.sh_res = {b[0], b[`DATA_W-1:1]};
			rotate_right_thru_carry, rotate_right_thru_carry_copy:
			begin
				bus.sh_res = {bus.carry_in, b[`DATA_W-1:1]};
				bus.sh_c = b[0];
			end
			decrement_skip_on_zero, decrement_skip_on_zero_copy:
				bus.sh_res = b - `ONE_VAL;
			increment_skip_on_zero, increment_skip_on_zero_copy:
				bus.sh_res = b + `ONE_VAL;
			byte_set:
				bus.sh_res = `ALL_ONES;
			bit_set:
				bus.sh_res = b | (`ONE_VAL << bus.bit_sel);
			nibble_swap:
				bus.sh_res = {b[`NIB_W-1:0], b[`DATA_W-1:`NIB_W]};
			default:
				bus.sh_res = b;
		endcase
	end
endmodule : shift_unit

// ===== rotate_subtract_skip_alu.sv
// execution datapath for rotates, subtracts, skips, set and swap
`include "alu_defs.svh"
module rotate_subtract_skip_alu (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic op_valid,
	input wire alu_pkg::op_t op_code,
	input wire logic [`DATA_W-1:0] mem_operand,
	input wire logic [`DATA_W-1:0] imm_operand,
	input wire logic [`BIT_SEL_W-1:0] bit_select,
	output logic op_ready,
	output logic [`DATA_W-1:0] working_register,
	output logic mem_write,
	output logic [`DATA_W-1:0] mem_write_data,
	output logic carry_flag,
	output logic zero_flag,
	output logic half_carry_flag,
	output logic signed_wrap_flag,
	output logic signed_carry_flag,
	output logic chained_zero_flag,
	output logic skip_next,
	output logic dummy_slot
);
	import alu_pkg::*;

	core_state_t cur_q;
	core_state_t nxt_d;
	logic take;
	logic [`DATA_W-1:0] result;
	alu_if bus ();

	function automatic logic is_subtract(input op_t o);
		return o inside {subtract_plain, subtract_immediate, difference_to_memory,
			subtract_with_borrow, subtract_borrow_immediate, subtract_borrow_to_memory};
	endfunction : is_subtract

	function automatic logic is_borrow(input op_t o);
		return o inside {subtract_with_borrow, subtract_borrow_immediate,
			subtract_borrow_to_memory};
	endfunction : is_borrow

	function automatic logic is_skip(input op_t o);
		return o inside {decrement_skip_on_zero, decrement_skip_on_zero_copy,
			increment_skip_on_zero, increment_skip_on_zero_copy,
			skip_if_nonzero, skip_if_nonzero_bit};
	endfunction : is_skip

	function automatic logic to_memory(input op_t o);
		return o inside {rotate_left_thru_carry, rotate_right, rotate_right_thru_carry,
			difference_to_memory, subtract_borrow_to_memory, decrement_skip_on_zero,
			increment_skip_on_zero, byte_set, bit_set, nibble_swap};
	endfunction : to_memory

	function automatic logic to_register(input op_t o);
		return o inside {rotate_left_copy, rotate_left_thru_carry_copy, rotate_right_copy,
			rotate_right_thru_carry_copy, subtract_plain, subtract_immediate,
			subtract_with_borrow, subtract_borrow_immediate,
			decrement_skip_on_zero_copy, increment_skip_on_zero_copy};
	endfunction : to_register

	function automatic logic moves_carry(input op_t o);
		return o inside {rotate_left_thru_carry, rotate_left_thru_carry_copy,
			rotate_right_thru_carry, rotate_right_thru_carry_copy};
	endfunction : moves_carry

	// a skip instruction holds the issue port for its dummy slot
	assign op_ready = (cur_q.phase == run);
	assign take = op_valid && op_ready;

	// the immediate forms take their subtrahend from the immediate field
	assign bus.opa = cur_q.wreg;
	assign bus.opb = (op_code inside {subtract_immediate, subtract_borrow_immediate})
		? imm_operand : mem_operand;
	assign bus.carry_in = cur_q.fl.c;
	assign bus.use_borrow = is_borrow(op_code);
	assign bus.op = op_code;
	assign bus.bit_sel = bit_select;

	sub_unit subtractor (
		.bus(bus)
	);

	shift_unit shifter (
		.bus(bus)
	);

	assign result = is_subtract(op_code) ? bus.diff : bus.sh_res;

	always_comb
	begin
		nxt_d = cur_q;
		nxt_d.mem_we = 1'b0;
		nxt_d.skip = 1'b0;
		unique case (cur_q.phase)
			run:
			begin
				if (take)
				begin
					if (to_memory(op_code))
					begin
						// memory forms leave the working register alone
						nxt_d.mem_we = 1'b1;
						nxt_d.mem_data = result;
					end
					else if (to_register(op_code))
					begin
						// copy forms never write back to memory
						nxt_d.wreg = result;
					end
					if (moves_carry(op_code))
					begin
						nxt_d.fl.c = bus.sh_c;
					end
					if (is_subtract(op_code))
					begin
						nxt_d.fl.c = bus.sub_c;
						nxt_d.fl.z = (bus.diff == `ZERO_VAL);
						nxt_d.fl.half_carry = bus.sub_half_carry;
						nxt_d.fl.signed_wrap = bus.sub_signed_wrap;
						nxt_d.fl.signed_carry = bus.sub_signed_carry;
						// borrow forms chain the zero test across a multi-byte subtract
						nxt_d.fl.chained_zero = is_borrow(op_code)
							? ((bus.diff == `ZERO_VAL) && cur_q.fl.chained_zero)
							: (bus.diff == `ZERO_VAL);
					end
					if (is_skip(op_code))
					begin
						nxt_d.phase = dummy;
						unique case (op_code)
							skip_if_nonzero:
								nxt_d.skip = (mem_operand != `ZERO_VAL);
							skip_if_nonzero_bit:
								nxt_d.skip = mem_operand[bit_select];
							default:
								nxt_d.skip = (bus.sh_res == `ZERO_VAL);
						endcase
					end
				end
			end
			dummy:
			begin
				// the slot executes nothing; the next fetch is still in flight
				nxt_d.phase = run;
			end
			default:
			begin
				nxt_d.phase = run;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			cur_q.phase <= run;
			cur_q.wreg <= `WREG_RST;
			cur_q.mem_we <= 1'b0;
			cur_q.mem_data <= `ZERO_VAL;
			cur_q.fl <= '{default: `FLAG_RST};
			cur_q.skip <= 1'b0;
		end
		else
		begin
			cur_q <= nxt_d;
		end
	end

	assign working_register = cur_q.wreg;
	assign mem_write = cur_q.mem_we;
	assign mem_write_data = cur_q.mem_data;
	assign carry_flag = cur_q.fl.c;
	assign zero_flag = cur_q.fl.z;
	assign half_carry_flag = cur_q.fl.half_carry;
	assign signed_wrap_flag = cur_q.fl.signed_wrap;
	assign signed_carry_flag = cur_q.fl.signed_carry;
	assign chained_zero_flag = cur_q.fl.chained_zero;
	assign skip_next = cur_q.skip;
	assign dummy_slot = (cur_q.phase == dummy);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	rot_left_copy_a: assert property (
		take && op_code == rotate_left_copy |=>
			working_register == {$past(mem_operand[`DATA_W-2:0]), $past(mem_operand[`MSB_BIT])}
			&& !mem_write && carry_flag == $past(carry_flag))
		else $error("copy rotate left result wrong");

	rot_left_carry_a: assert property (
		take && op_code == rotate_left_thru_carry |=>
			mem_write && carry_flag == $past(mem_operand[`MSB_BIT])
			&& mem_write_data == {$past(mem_operand[`DATA_W-2:0]), $past(carry_flag)}
			&& working_register == $past(working_register))
		else $error("rotate left through carry wrong");

	rot_left_cc_a: assert property (
		take && op_code == rotate_left_thru_carry_copy |=>
			!mem_write && carry_flag == $past(mem_operand[`MSB_BIT])
			&& working_register == {$past(mem_operand[`DATA_W-2:0]), $past(carry_flag)})
		else $error("copy rotate left through carry wrong");

	rot_right_mem_a: assert property (
		take && op_code == rotate_right |=>
			mem_write && mem_write_data == {$past(mem_operand[0]), $past(mem_operand[`DATA_W-1:1])}
			&& $stable(zero_flag) && $stable(carry_flag))
		else $error("rotate right result wrong");

	rot_right_copy_a: assert property (
		take && op_code == rotate_right_copy |=>
			!mem_write && $stable(carry_flag)
			&& working_register == {$past(mem_operand[0]), $past(mem_operand[`DATA_W-1:1])})
		else $error("copy rotate right result wrong");

	rot_right_carry_a: assert property (
		take && op_code == rotate_right_thru_carry |=>
			mem_write && carry_flag == $past(mem_operand[0])
			&& mem_write_data == {$past(carry_flag), $past(mem_operand[`DATA_W-1:1])})
		else $error("rotate right through carry wrong");

	rot_right_cc_a: assert property (
		take && op_code == rotate_right_thru_carry_copy |=>
			!mem_write && carry_flag == $past(mem_operand[0])
			&& working_register == {$past(carry_flag), $past(mem_operand[`DATA_W-1:1])})
		else $error("copy rotate right through carry wrong");

	sub_borrow_a: assert property (
		take && op_code == subtract_with_borrow |=>
			working_register == $past(working_register) - $past(mem_operand)
				- {{(`DATA_W-1){1'b0}}, !$past(carry_flag)} && !mem_write)
		else $error("subtract with borrow wrong");

	sub_borrow_imm_a: assert property (
		take && op_code == subtract_borrow_immediate |=>
			working_register == $past(working_register) - $past(imm_operand)
				- {{(`DATA_W-1){1'b0}}, !$past(carry_flag)})
		else $error("immediate subtract with borrow wrong");

	sub_borrow_mem_a: assert property (
		take && op_code == subtract_borrow_to_memory |=>
			mem_write && working_register == $past(working_register)
			&& mem_write_data == $past(working_register) - $past(mem_operand)
				- {{(`DATA_W-1){1'b0}}, !$past(carry_flag)})
		else $error("subtract with borrow to memory wrong");

	sub_zero_flag_a: assert property (
		take && op_code == subtract_plain |=>
			zero_flag == (working_register == `ZERO_VAL)
			&& chained_zero_flag == zero_flag
			&& half_carry_flag == ($past(working_register[`HALF_BIT:0])
				>= $past(mem_operand[`HALF_BIT:0])))
		else $error("subtract flags wrong");

	sub_carry_a: assert property (
		take && op_code inside {subtract_plain, difference_to_memory} |=>
			carry_flag == ($past(working_register) >= $past(mem_operand)))
		else $error("subtract carry sense wrong");

	diff_mem_a: assert property (
		take && op_code == difference_to_memory |=>
			mem_write && mem_write_data == $past(working_register) - $past(mem_operand))
		else $error("difference to memory wrong");

	sequence skip_taken;
		take && is_skip(op_code);
	endsequence

	sequence dummy_then_free;
		dummy_slot && !op_ready ##1 !dummy_slot && op_ready && !skip_next;
	endsequence

	skip_slot_a: assert property (
		skip_taken |=> dummy_then_free)
		else $error("skip did not take two cycles");

	dec_skip_a: assert property (
		take && op_code == decrement_skip_on_zero |=>
			mem_write && mem_write_data == $past(mem_operand) - `ONE_VAL
			&& skip_next == ($past(mem_operand) == `ONE_VAL))
		else $error("decrement and skip wrong");

	dec_copy_a: assert property (
		take && op_code == decrement_skip_on_zero_copy |=>
			!mem_write && working_register == $past(mem_operand) - `ONE_VAL
			&& skip_next == (working_register == `ZERO_VAL))
		else $error("copy decrement and skip wrong");

	inc_skip_a: assert property (
		take && op_code == increment_skip_on_zero |=>
			mem_write && mem_write_data == $past(mem_operand) + `ONE_VAL
			&& skip_next == ($past(mem_operand) == `ALL_ONES) && $stable(carry_flag))
		else $error("increment and skip wrong");

	inc_copy_a: assert property (
		take && op_code == increment_skip_on_zero_copy |=>
			!mem_write && working_register == $past(mem_operand) + `ONE_VAL
			&& skip_next == (working_register == `ZERO_VAL))
		else $error("copy increment and skip wrong");

	nonzero_skip_a: assert property (
		take && op_code == skip_if_nonzero_bit |=>
			skip_next == $past(mem_operand[bit_select]) && !mem_write
			&& $stable(zero_flag))
		else $error("bit skip if nonzero wrong");

	byte_set_a: assert property (
		take && op_code == byte_set |=>
			mem_write && mem_write_data == `ALL_ONES && $stable(carry_flag))
		else $error("byte set wrong");

	bit_set_a: assert property (
		take && op_code == bit_set |=>
			mem_write && mem_write_data[$past(bit_select)]
			&& (mem_write_data & ~(`ONE_VAL << $past(bit_select)))
				== ($past(mem_operand) & ~(`ONE_VAL << $past(bit_select))))
		else $error("bit set wrong");

	nibble_swap_a: assert property (
		take && op_code == nibble_swap |=>
			mem_write && mem_write_data == {$past(mem_operand[`NIB_W-1:0]),
				$past(mem_operand[`DATA_W-1:`NIB_W])} && $stable(zero_flag))
		else $error("nibble swap wrong");

	write_pulse_a: assert property (
		mem_write |=> !mem_write || $past(take))
		else $error("memory write not tied to an instruction");
endmodule : rotate_subtract_skip_alu

// ===== testbench.sv
// self-checking bench for the rotate, subtract and skip datapath
`include "alu_defs.svh"
`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end

module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import alu_pkg::*;

	logic clk;
	logic rst_b;
	logic op_valid;
	op_t op_code;
	logic [7:0] mem_operand;
	logic [7:0] imm_operand;
	logic [2:0] bit_select;
	logic op_ready;
	logic [7:0] working_register;
	logic mem_write;
	logic [7:0] mem_write_data;
	logic carry_flag;
	logic zero_flag;
	logic half_carry_flag;
	logic signed_wrap_flag;
	logic signed_carry_flag;
	logic chained_zero_flag;
	logic skip_next;
	logic dummy_slot;
	int n_errors;
	int samples_checked;
	// expected state, kept by the bench alone
	logic [7:0] e_w;
	logic [7:0] e_md;
	logic e_mw;
	logic e_sk;
	logic e_c;
	logic e_z;
	logic e_half;
	logic e_wrap;
	logic e_sgn;
	logic e_chain;

	rotate_subtract_skip_alu u_rotate_subtract_skip_alu (
		.clk(clk),
		.rst_b(rst_b),
		.op_valid(op_valid),
		.op_code(op_code),
		.mem_operand(mem_operand),
		.imm_operand(imm_operand),
		.bit_select(bit_select),
		.op_ready(op_ready),
		.working_register(working_register),
		.mem_write(mem_write),
		.mem_write_data(mem_write_data),
		.carry_flag(carry_flag),
		.zero_flag(zero_flag),
		.half_carry_flag(half_carry_flag),
		.signed_wrap_flag(signed_wrap_flag),
		.signed_carry_flag(signed_carry_flag),
		.chained_zero_flag(chained_zero_flag),
		.skip_next(skip_next),
		.dummy_slot(dummy_slot)
	);

	always #50 clk = ~clk;

	task close_out;
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// returns {no borrow, no nibble borrow, signed overflow, difference}
	function automatic logic [10:0] sub_calc(input logic [7:0] a, b, input logic bw);
		logic [8:0] d;
		logic [4:0] h;
		d = {1'b0, a} - {1'b0, b} - {8'h00, bw};
		h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
		return {~d[8], ~h[4], (a[7] != b[7]) && (d[7] != a[7]), d[7:0]};
	endfunction : sub_calc

	function automatic logic is_skip(input op_t op);
		return op inside {decrement_skip_on_zero, decrement_skip_on_zero_copy,
			increment_skip_on_zero, increment_skip_on_zero_copy,
			skip_if_nonzero, skip_if_nonzero_bit};
	endfunction : is_skip

	task automatic model(input op_t op, input logic [7:0] m, imm, input logic [2:0] bs);
		logic [10:0] s;
		logic [7:0] r;
		logic [7:0] b;
		logic [1:0] dst;
		logic bf;
		e_mw = 1'b0;
		e_sk = 1'b0;
		dst = 2'd0;
		r = 8'h00;
		bf = op inside {subtract_with_borrow, subtract_borrow_immediate, subtract_borrow_to_memory};
		b = (op inside {subtract_immediate, subtract_borrow_immediate}) ? imm : m;
		if (op inside {subtract_plain, subtract_immediate, difference_to_memory} || bf)
		begin
			s = sub_calc(e_w, b, bf & ~e_c);
			r = s[7:0];
			{e_c, e_half, e_wrap} = s[10:8];
			e_z = (r == 8'h00);
			e_sgn = e_wrap ^ r[7];
			e_chain = bf ? (e_z & e_chain) : e_z;
			dst = (op inside {difference_to_memory, subtract_borrow_to_memory}) ? 2'd2 : 2'd1;
		end
		else
			case (op)
				rotate_left_copy: {dst, r} = {2'd1, m[6:0], m[7]};
				rotate_left_thru_carry: {dst, r, e_c} = {2'd2, m[6:0], e_c, m[7]};
				rotate_left_thru_carry_copy: {dst, r, e_c} = {2'd1, m[6:0], e_c, m[7]};
				rotate_right: {dst, r} = {2'd2, m[0], m[7:1]};
				rotate_right_copy: {dst, r} = {2'd1, m[0], m[7:1]};
				rotate_right_thru_carry: {dst, r, e_c} = {2'd2, e_c, m[7:1], m[0]};
				rotate_right_thru_carry_copy: {dst, r, e_c} = {2'd1, e_c, m[7:1], m[0]};
				decrement_skip_on_zero: {dst, r, e_sk} = {2'd2, m - 8'h01, m == 8'h01};
				decrement_skip_on_zero_copy: {dst, r, e_sk} = {2'd1, m - 8'h01, m == 8'h01};
				increment_skip_on_zero: {dst, r, e_sk} = {2'd2, m + 8'h01, m == 8'hff};
				increment_skip_on_zero_copy: {dst, r, e_sk} = {2'd1, m + 8'h01, m == 8'hff};
				skip_if_nonzero: e_sk = (m != 8'h00);
				skip_if_nonzero_bit: e_sk = m[bs];
				byte_set: {dst, r} = {2'd2, 8'hff};
				bit_set: {dst, r} = {2'd2, m | (8'h01 << bs)};
				nibble_swap: {dst, r} = {2'd2, m[3:0], m[7:4]};
				default: ;
			endcase
		if (dst == 2'd1)
			e_w = r;
		if (dst == 2'd2)
		begin
			e_mw = 1'b1;
			e_md = r;
		end
	endtask : model

	task check_all;
		`CHK(working_register, e_w)
		`CHK(mem_write, e_mw)
		`CHK(mem_write_data, e_md)
		`CHK(carry_flag, e_c)
		`CHK({zero_flag, half_carry_flag, signed_wrap_flag}, {e_z, e_half, e_wrap})
		`CHK({signed_carry_flag, chained_zero_flag}, {e_sgn, e_chain})
		`CHK(skip_next, e_sk)
	endtask : check_all

	// inputs change 1 ns after the edge; a skip op gets its dummy cycle checked too
	task automatic run_op(input op_t op, input logic [7:0] m, imm, input logic [2:0] bs);
		logic skc;
		skc = is_skip(op);
		op_valid = 1'b1;
		op_code = op;
		mem_operand = m;
		imm_operand = imm;
		bit_select = bs;
		`CHK(op_ready, 1'b1)
		model(op, m, imm, bs);
		@(posedge clk);
		#1;
		check_all;
		`CHK(dummy_slot, skc)
		if (skc)
		begin
			`CHK(op_ready, 1'b0)
			op_code = byte_set;
			mem_operand = 8'($urandom);
			e_mw = 1'b0;
			e_sk = 1'b0;
			@(posedge clk);
			#1;
			check_all;
			`CHK(dummy_slot, 1'b0)
		end
	endtask : run_op

	task do_reset;
		rst_b = 1'b0;
		op_valid = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		rst_b = 1'b1;
		{e_w, e_md, e_mw, e_sk} = '0;
		{e_c, e_z, e_half, e_wrap, e_sgn, e_chain} = '0;
		check_all;
		`CHK(dummy_slot, 1'b0)
	endtask : do_reset

	initial
	begin
		#2000000;
		n_errors++;
		close_out;
	end

	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		op_valid = 1'b0;
		op_code = nop;
		mem_operand = 8'h00;
		imm_operand = 8'h00;
		bit_select = 3'h0;
		n_errors = 0;
		samples_checked = 0;
		void'($urandom(32'h2be8));
		do_reset;
		run_op(rotate_left_copy, 8'h82, 8'h00, 3'h0);
		run_op(subtract_plain, 8'h07, 8'h00, 3'h0);
		run_op(subtract_with_borrow, 8'h00, 8'h00, 3'h0);
		run_op(subtract_borrow_immediate, 8'h00, 8'hfc, 3'h0);
		run_op(subtract_immediate, 8'h00, 8'h80, 3'h0);
		run_op(subtract_borrow_to_memory, 8'hff, 8'h00, 3'h0);
		run_op(difference_to_memory, 8'h01, 8'h00, 3'h0);
		run_op(decrement_skip_on_zero, 8'h01, 8'h00, 3'h0);
		run_op(decrement_skip_on_zero, 8'h00, 8'h00, 3'h0);
		run_op(decrement_skip_on_zero_copy, 8'h01, 8'h00, 3'h0);
		run_op(increment_skip_on_zero, 8'hff, 8'h00, 3'h0);
		run_op(increment_skip_on_zero_copy, 8'hff, 8'h00, 3'h0);
		run_op(increment_skip_on_zero_copy, 8'h00, 8'h00, 3'h0);
		run_op(skip_if_nonzero, 8'h00, 8'h00, 3'h0);
		run_op(skip_if_nonzero, 8'h5a, 8'h00, 3'h0);
		run_op(rotate_left_thru_carry, 8'h80, 8'h00, 3'h0);
		run_op(rotate_right_thru_carry, 8'h01, 8'h00, 3'h0);
		run_op(rotate_right_thru_carry_copy, 8'h00, 8'h00, 3'h0);
		run_op(rotate_right, 8'h01, 8'h00, 3'h0);
		run_op(rotate_right_copy, 8'h80, 8'h00, 3'h0);
		run_op(nibble_swap, 8'ha5, 8'h00, 3'h0);
		run_op(byte_set, 8'h00, 8'h00, 3'h0);
		for (int i = 0; i < 8; i++)
		begin
			run_op(bit_set, 8'h00, 8'h00, 3'(i));
			run_op(skip_if_nonzero_bit, 8'h01 << i, 8'h00, 3'(i));
			run_op(skip_if_nonzero_bit, 8'h01 << i, 8'h00, 3'(i ^ 1));
		end
		// every code once, including the unused ones that must change nothing
		for (int k = 0; k < 32; k++)
			run_op(op_t'(5'(k)), 8'($urandom), 8'($urandom), 3'($urandom));
		do_reset;
		repeat (600)
			run_op(op_t'(5'($urandom_range(0, 24))), 8'($urandom), 8'($urandom), 3'($urandom));
		op_valid = 1'b0;
		e_mw = 1'b0;
		e_sk = 1'b0;
		@(posedge clk);
		#1;
		check_all;
		close_out;
	end
endmodule : testbench
